// >>> include/acp_pkg.sv
package acp_pkg;
  localparam logic [7:0] ACP_CH_NL     = 8'h0A;
  localparam logic [7:0] ACP_CH_COLON  = 8'h3A;
  localparam logic [7:0] ACP_CH_QUERY  = 8'h3F;
  localparam logic [7:0] ACP_CH_SEMI   = 8'h3B;
  localparam logic [7:0] ACP_CH_STAR   = 8'h2A;
  localparam logic [7:0] ACP_CH_COMMA  = 8'h2C;
  localparam logic [7:0] ACP_CH_SPACE  = 8'h20;
  localparam logic [7:0] ACP_CH_TAB    = 8'h09;
  localparam logic [7:0] ACP_CH_DOT    = 8'h2E;
  localparam logic [7:0] ACP_CH_ZERO   = 8'h30;
  localparam logic [7:0] ACP_CH_NINE   = 8'h39;
  localparam logic [7:0] ACP_CH_PLUS   = 8'h2B;
  localparam logic [7:0] ACP_CH_MINUS  = 8'h2D;
  localparam logic [7:0] ACP_CH_E      = 8'h45;
  localparam int         ACP_KW_MAX    = 12;
  localparam int         ACP_KW_SHORT  = 4;
  localparam int         ACP_ESR_CME   = 5;
  localparam logic [15:0] ACP_SLOT_MAX1 = 16'h012C;
  localparam logic [15:0] ACP_SLOT_MAX2 = 16'h0096;
  localparam logic [15:0] ACP_SLOT_MAX4 = 16'h0078;
  localparam logic [15:0] ACP_SLOT_MIN  = 16'h0001;
  localparam logic [15:0] ACP_NUM_LIMIT = 16'h0FFF;
  localparam logic [3:0]  ACP_TEN       = 4'hA;
  // identity strings: arbitrary neutral values
  localparam int          ACP_ID_LEN    = 24;
  localparam logic [8*ACP_ID_LEN-1:0] ACP_ID_TEXT = "ACME,MODEL0,SN0000,V0.0.";
  // keyword table indices
  typedef enum logic [2:0] {
    ACP_KW_NONE = 3'h0,
    ACP_KW_IDN  = 3'h1,
    ACP_KW_RST  = 3'h2,
    ACP_KW_RCL  = 3'h3
  } acp_kw_t;
  typedef enum logic [5:0] {
    ACP_ST_HDR  = 6'b000001,
    ACP_ST_WS   = 6'b000010,
    ACP_ST_PAR  = 6'b000100,
    ACP_ST_SKIP = 6'b001000,
    ACP_ST_EXEC = 6'b010000,
    ACP_ST_RESP = 6'b100000
  } acp_state_t;
  typedef enum logic [1:0] {
    ACP_CH1 = 2'h0,
    ACP_CH2 = 2'h1,
    ACP_CH4 = 2'h2
  } acp_chan_t;
endpackage

// >>> core/acp_kw_match.sv
`timescale 1ns/1ns
`default_nettype none
module acp_kw_match
  import acp_pkg::*;
#(
  parameter int                    LONG_LEN  = 4,
  parameter logic [8*12-1:0]       LONG_TEXT = "TEXT        "
) (
  // candidate keyword, upper case, first letter at [7:0]
  input  wire logic [8*12-1:0] i_kw,
  input  wire logic [3:0]      i_len,
  // result
  output logic                 o_hit
);
  function automatic int short_len(input int len, input logic [7:0] c4);
    if (len <= ACP_KW_SHORT) begin
      return len;
    end
    if (c4 == 8'h41 || c4 == 8'h45 || c4 == 8'h49 || c4 == 8'h4F || c4 == 8'h55) begin
      return 3;
    end
    return 4;
  endfunction

  localparam int SLEN = short_len(LONG_LEN, LONG_TEXT[8*12-1-8*3 -: 8]);

  logic pre_ok;
  always_comb begin
    pre_ok = 1'b1;
    for (int k = 0; k < 12; k++) begin
      if (k < int'(i_len) && i_kw[8*k +: 8] != LONG_TEXT[8*12-1-8*k -: 8]) begin
        pre_ok = 1'b0;
      end
    end
    // only full long form or exact short form, no other truncation
    o_hit = pre_ok && (int'(i_len) == LONG_LEN || int'(i_len) == SLEN);
  end
endmodule
`default_nettype wire

// >>> core/acp_parser.sv
`timescale 1ns/1ns
`default_nettype none
module acp_parser
  import acp_pkg::*;
(
  // clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rstn,
  // incoming characters
  input  wire logic              i_rx_valid,
  input  wire logic [7:0]        i_rx_data,
  output logic                   o_rx_ready,
  // configuration
  input  wire acp_pkg::acp_chan_t i_chan_cfg,
  // response characters
  output logic                   o_tx_valid,
  output logic [7:0]             o_tx_data,
  input  wire logic              i_tx_ready,
  // actions
  output logic                   o_rst_pulse,
  output logic                   o_rcl_pulse,
  output logic [15:0]            o_rcl_slot,
  output logic                   o_tree_pulse,
  output logic [3:0]             o_tree_depth,
  output logic [7:0]             o_esr
);
  import acp_pkg::*;

  acp_state_t        state_reg,   state_next;
  logic [8*12-1:0]   kw_reg,      kw_next;
  logic [3:0]        kwlen_reg,   kwlen_next;
  logic              common_reg,  common_next;
  logic              query_reg,   query_next;
  logic [3:0]        depth_reg,   depth_next;
  logic [15:0]       num_reg,     num_next;
  logic [3:0]        npar_reg,    npar_next;
  logic              nerr_reg,    nerr_next;
  logic              ndig_reg,    ndig_next;
  logic [1:0]        nfmt_reg,    nfmt_next;
  logic              eol_reg,     eol_next;
  logic [4:0]        tidx_reg,    tidx_next;
  logic              txv_reg,     txv_next;
  logic [7:0]        txd_reg,     txd_next;
  logic              rstp_reg,    rstp_next;
  logic              rclp_reg,    rclp_next;
  logic [15:0]       slot_reg,    slot_next;
  logic              treep_reg,   treep_next;
  logic [7:0]        esr_reg,     esr_next;
  logic              rdy_reg,     rdy_next;

  logic              hit_idn;
  logic              hit_rst;
  logic              hit_rcl;
  logic [7:0]        up;
  logic              take;

  function automatic logic [7:0] to_upper(input logic [7:0] c);
    return (c >= 8'h61 && c <= 8'h7A) ? c - 8'h20 : c;
  endfunction

  function automatic logic is_digit(input logic [7:0] c);
    return c >= ACP_CH_ZERO && c <= ACP_CH_NINE;
  endfunction

  function automatic logic [15:0] slot_max(input acp_chan_t ch);
    case (ch)
      ACP_CH2: return ACP_SLOT_MAX2;
      ACP_CH4: return ACP_SLOT_MAX4;
      default: return ACP_SLOT_MAX1;
    endcase
  endfunction

  acp_kw_match #(.LONG_LEN(3), .LONG_TEXT("IDN         ")) u_idn (
    .i_kw(kw_reg), .i_len(kwlen_reg), .o_hit(hit_idn));
  acp_kw_match #(.LONG_LEN(3), .LONG_TEXT("RST         ")) u_rst (
    .i_kw(kw_reg), .i_len(kwlen_reg), .o_hit(hit_rst));
  acp_kw_match #(.LONG_LEN(3), .LONG_TEXT("RCL         ")) u_rcl (
    .i_kw(kw_reg), .i_len(kwlen_reg), .o_hit(hit_rcl));

  assign up   = to_upper(i_rx_data);
  assign take = i_rx_valid && rdy_reg;

  always_comb begin
    state_next  = state_reg;
    kw_next     = kw_reg;
    kwlen_next  = kwlen_reg;
    common_next = common_reg;
    query_next  = query_reg;
    depth_next  = depth_reg;
    num_next    = num_reg;
    npar_next   = npar_reg;
    nerr_next   = nerr_reg;
    ndig_next   = ndig_reg;
    nfmt_next   = nfmt_reg;
    eol_next    = eol_reg;
    tidx_next   = tidx_reg;
    txv_next    = txv_reg;
    txd_next    = txd_reg;
    rstp_next   = 1'b0;
    rclp_next   = 1'b0;
    slot_next   = slot_reg;
    treep_next  = 1'b0;
    esr_next    = esr_reg;
    rdy_next    = rdy_reg;
    case (state_reg)
      ACP_ST_HDR, ACP_ST_WS, ACP_ST_PAR: begin
        if (take) begin
          if (up == ACP_CH_NL || up == ACP_CH_SEMI) begin
            eol_next   = (up == ACP_CH_NL);
            state_next = ACP_ST_EXEC;
            rdy_next   = 1'b0;
          end else if (state_reg == ACP_ST_HDR) begin
            if (up == ACP_CH_STAR && kwlen_reg == 4'h0 && depth_reg == 4'h0) begin
              common_next = 1'b1;
            end else if (up == ACP_CH_COLON) begin
              depth_next = (depth_reg == 4'hF) ? depth_reg : depth_reg + 4'h1;
              kwlen_next = 4'h0;
              treep_next = 1'b1;
            end else if (up == ACP_CH_QUERY) begin
              query_next = 1'b1;
            end else if (up == ACP_CH_SPACE || up == ACP_CH_TAB) begin
              state_next = ACP_ST_WS;
            end else if (query_reg || int'(kwlen_reg) >= ACP_KW_MAX) begin
              state_next = ACP_ST_SKIP;
            end else begin
              kw_next[8*kwlen_reg +: 8] = up;
              kwlen_next = kwlen_reg + 4'h1;
            end
          end else begin
            if (up == ACP_CH_SPACE || up == ACP_CH_TAB) begin
              state_next = state_reg;
            end else if (up == ACP_CH_COMMA) begin
              npar_next = (npar_reg == 4'hF) ? npar_reg : npar_reg + 4'h1;
              ndig_next = 1'b0;
              nfmt_next = 2'h0;
            end else begin
              state_next = ACP_ST_PAR;
              if (is_digit(up)) begin
                ndig_next = 1'b1;
                if (nfmt_reg == 2'h0 && npar_reg == 4'h0) begin
                  num_next = (num_reg > ACP_NUM_LIMIT) ? num_reg
                           : 16'(num_reg * ACP_TEN + 16'(up - ACP_CH_ZERO));
                  nerr_next = nerr_reg | (num_reg > ACP_NUM_LIMIT);
                end
              end else if (up == ACP_CH_DOT && nfmt_reg == 2'h0) begin
                nfmt_next = 2'h1;
              end else if (up == ACP_CH_E && ndig_reg && nfmt_reg != 2'h2) begin
                nfmt_next = 2'h2;
              end else if (!((up == ACP_CH_PLUS || up == ACP_CH_MINUS) && nfmt_reg == 2'h2)) begin
                nerr_next = 1'b1;
              end
            end
          end
        end
      end
      ACP_ST_SKIP: begin
        if (take && (up == ACP_CH_NL || up == ACP_CH_SEMI)) begin
          eol_next   = (up == ACP_CH_NL);
          esr_next[ACP_ESR_CME] = 1'b1;
          state_next = ACP_ST_RESP;
          rdy_next   = 1'b0;
        end
      end
      ACP_ST_EXEC: begin
        state_next = eol_reg ? ACP_ST_RESP : ACP_ST_HDR;
        rdy_next   = !eol_reg;
        if (common_reg && hit_idn && query_reg && npar_reg == 4'h0 && !ndig_reg) begin
          tidx_next  = 5'h0;
          txv_next   = 1'b1;
          txd_next   = ACP_ID_TEXT[8*ACP_ID_LEN-1 -: 8];
          state_next = ACP_ST_RESP;
          rdy_next   = 1'b0;
        end else if (common_reg && hit_rst && !query_reg && !ndig_reg) begin
          rstp_next = 1'b1;
        end else if (common_reg && hit_rcl && !query_reg && ndig_reg && !nerr_reg
                     && nfmt_reg == 2'h0 && npar_reg == 4'h0) begin
          if (num_reg >= ACP_SLOT_MIN && num_reg <= slot_max(i_chan_cfg)) begin
            rclp_next = 1'b1;
            slot_next = num_reg;
          end else begin
            esr_next[ACP_ESR_CME] = 1'b1;
          end
        end else if (!(kwlen_reg == 4'h0 && !common_reg && depth_reg == 4'h0)) begin
          esr_next[ACP_ESR_CME] = 1'b1;
        end
      end
      ACP_ST_RESP: begin
        if (!txv_reg) begin
          state_next = ACP_ST_HDR;
          rdy_next   = 1'b1;
        end else if (i_tx_ready) begin
          if (int'(tidx_reg) == ACP_ID_LEN - 1) begin
            txd_next  = ACP_CH_NL;
            tidx_next = tidx_reg + 5'h1;
          end else if (int'(tidx_reg) >= ACP_ID_LEN) begin
            txv_next = 1'b0;
          end else begin
            tidx_next = tidx_reg + 5'h1;
            txd_next  = ACP_ID_TEXT[8*ACP_ID_LEN-1-8*(int'(tidx_reg)+1) -: 8];
          end
        end
      end
      default: begin
        state_next = ACP_ST_HDR;
        rdy_next   = 1'b1;
      end
    endcase
    if (state_next == ACP_ST_HDR && state_reg != ACP_ST_HDR) begin
      kwlen_next  = 4'h0;
      kw_next     = '0;
      common_next = 1'b0;
      query_next  = 1'b0;
      num_next    = 16'h0000;
      npar_next   = 4'h0;
      nerr_next   = 1'b0;
      ndig_next   = 1'b0;
      nfmt_next   = 2'h0;
      depth_next  = eol_next ? 4'h0 : depth_reg;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg  <= ACP_ST_HDR;
      kw_reg     <= '0;
      kwlen_reg  <= 4'h0;
      common_reg <= 1'b0;
      query_reg  <= 1'b0;
      depth_reg  <= 4'h0;
      num_reg    <= 16'h0000;
      npar_reg   <= 4'h0;
      nerr_reg   <= 1'b0;
      ndig_reg   <= 1'b0;
      nfmt_reg   <= 2'h0;
      eol_reg    <= 1'b0;
      tidx_reg   <= 5'h00;
      txv_reg    <= 1'b0;
      txd_reg    <= 8'h00;
      rstp_reg   <= 1'b0;
      rclp_reg   <= 1'b0;
      slot_reg   <= 16'h0000;
      treep_reg  <= 1'b0;
      esr_reg    <= 8'h00;
      rdy_reg    <= 1'b1;
    end else begin
      state_reg  <= state_next;
      kw_reg     <= kw_next;
      kwlen_reg  <= kwlen_next;
      common_reg <= common_next;
      query_reg  <= query_next;
      depth_reg  <= depth_next;
      num_reg    <= num_next;
      npar_reg   <= npar_next;
      nerr_reg   <= nerr_next;
      ndig_reg   <= ndig_next;
      nfmt_reg   <= nfmt_next;
      eol_reg    <= eol_next;
      tidx_reg   <= tidx_next;
      txv_reg    <= txv_next;
      txd_reg    <= txd_next;
      rstp_reg   <= rstp_next;
      rclp_reg   <= rclp_next;
      slot_reg   <= slot_next;
      treep_reg  <= treep_next;
      esr_reg    <= esr_next;
      rdy_reg    <= rdy_next;
    end
  end

  assign o_rx_ready   = rdy_reg;
  assign o_tx_valid   = txv_reg;
  assign o_tx_data    = txd_reg;
  assign o_rst_pulse  = rstp_reg;
  assign o_rcl_pulse  = rclp_reg;
  assign o_rcl_slot   = slot_reg;
  assign o_tree_pulse = treep_reg;
  assign o_tree_depth = depth_reg;
  assign o_esr        = esr_reg;
endmodule
`default_nettype wire

// >>> verif/acp_parser_checker.sv
`timescale 1ns/1ns
`default_nettype none
module acp_parser_checker
  import acp_pkg::*;
(
  input wire logic               i_sys_clk,
  input wire logic               i_rstn,
  input wire logic               i_rx_valid,
  input wire logic [7:0]         i_rx_data,
  input wire logic               o_rx_ready,
  input wire acp_pkg::acp_chan_t i_chan_cfg,
  input wire logic               o_tx_valid,
  input wire logic [7:0]         o_tx_data,
  input wire logic               i_tx_ready,
  input wire logic               o_rst_pulse,
  input wire logic               o_rcl_pulse,
  input wire logic [15:0]        o_rcl_slot,
  input wire logic               o_tree_pulse,
  input wire logic [3:0]         o_tree_depth,
  input wire logic [7:0]         o_esr
);
  import acp_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  logic [15:0] slot_max;
  always_comb begin
    slot_max = (i_chan_cfg == ACP_CH2) ? ACP_SLOT_MAX2 : ((i_chan_cfg == ACP_CH4) ? ACP_SLOT_MAX4 : ACP_SLOT_MAX1);
  end
  sequence nl_taken;
    i_rx_valid && o_rx_ready && (i_rx_data == ACP_CH_NL);
  endsequence
  sequence semi_taken;
    i_rx_valid && o_rx_ready && (i_rx_data == ACP_CH_SEMI);
  endsequence
  sequence tx_stall;
    o_tx_valid && !i_tx_ready;
  endsequence
  line_end_a: assert property (nl_taken |=> !o_rx_ready)
    else $error("ready stayed high after newline");
  cmd_split_a: assert property (semi_taken |=> !o_rx_ready)
    else $error("ready stayed high after semicolon");
  tx_hold_a: assert property (tx_stall |=> o_tx_valid && $stable(o_tx_data))
    else $error("response char changed while stalled");
  resp_end_a: assert property ($fell(o_tx_valid) |-> $past(o_tx_data) == ACP_CH_NL)
    else $error("response did not end with newline");
  resp_lock_a: assert property (o_tx_valid |-> !o_rx_ready)
    else $error("input taken during response");
  rst_once_a: assert property (o_rst_pulse |=> !o_rst_pulse)
    else $error("reset pulse longer than one cycle");
  rcl_range_a: assert property (o_rcl_pulse |=> (o_rcl_slot >= ACP_SLOT_MIN) && (o_rcl_slot <= slot_max))
    else $error("recall slot outside range");
  cme_sticky_a: assert property (o_esr[ACP_ESR_CME] |=> o_esr[ACP_ESR_CME])
    else $error("command error flag cleared");
  tree_depth_a: assert property (o_tree_pulse |-> ##[0:1] (o_tree_depth != 4'h0))
    else $error("colon pulse without depth");
  depth_clear_a: assert property (nl_taken |-> ##[1:3] (o_tree_depth == 4'h0))
    else $error("depth not cleared after newline");
endmodule
bind acp_parser acp_parser_checker u_chk (
  .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data),
  .o_rx_ready(o_rx_ready), .i_chan_cfg(i_chan_cfg), .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
  .i_tx_ready(i_tx_ready), .o_rst_pulse(o_rst_pulse), .o_rcl_pulse(o_rcl_pulse), .o_rcl_slot(o_rcl_slot),
  .o_tree_pulse(o_tree_pulse), .o_tree_depth(o_tree_depth), .o_esr(o_esr)
);
`default_nettype wire

// >>> verif/acp_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module acp_host_model (
  // clock
  input  wire logic       i_sys_clk,
  // command characters
  input  wire logic       i_rx_ready,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data,
  // response characters
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_tx_ready
);
  logic       slow;
  logic [7:0] resp_q[$];
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data = 8'h00;
    o_tx_ready = 1'b1;
    slow = 1'b0;
  end
  // sink stalls every other cycle when slow
  always @(negedge i_sys_clk) begin
    o_tx_ready = slow ? ~o_tx_ready : 1'b1;
  end
  always @(posedge i_sys_clk) begin
    if (i_tx_valid && o_tx_ready) resp_q.push_back(i_tx_data);
  end
  // sends one whole line, each char held until taken
  task automatic send_line(input string s, output bit tmo);
    int    n;
    string line;
    line = {s, "\n"};
    tmo = 1'b0;
    for (int k = 0; k < line.len(); k++) begin
      @(negedge i_sys_clk);
      o_rx_valid = 1'b1;
      o_rx_data = line[k];
      n = 0;
      while (!i_rx_ready && n < 200) begin
        @(negedge i_sys_clk);
        n++;
      end
      if (n == 200) tmo = 1'b1;
      @(posedge i_sys_clk);
    end
    @(negedge i_sys_clk);
    o_rx_valid = 1'b0;
    o_rx_data = ~o_rx_data;
  endtask
endmodule
`default_nettype wire

// >>> verif/test_ascii_command_parser.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
  $display("ERROR at %0t: got %h expected %h", $time, (got), (exp)); end end
module test_ascii_command_parser;
  import acp_pkg::*;
  logic               clk;
  logic               rstn;
  logic               rx_valid;
  logic [7:0]         rx_data;
  logic               rx_ready;
  acp_pkg::acp_chan_t chan;
  logic               tx_valid;
  logic [7:0]         tx_data;
  logic               tx_ready;
  logic               rst_pulse;
  logic               rcl_pulse;
  logic [15:0]        rcl_slot;
  logic               tree_pulse;
  logic [3:0]         tree_depth;
  logic [7:0]         esr;
  logic [3:0]         max_depth;
  int                 error_cnt;
  int                 tests_run;
  int                 rst_cnt;
  int                 rcl_cnt;
  int                 tree_cnt;
  acp_chan_t          cfgs[3] = '{ACP_CH1, ACP_CH2, ACP_CH4};
  logic [15:0]        maxs[3] = '{ACP_SLOT_MAX1, ACP_SLOT_MAX2, ACP_SLOT_MAX4};
  always #5 clk = ~clk;
  acp_parser dut (
    .i_sys_clk(clk), .i_rstn(rstn), .i_rx_valid(rx_valid), .i_rx_data(rx_data), .o_rx_ready(rx_ready),
    .i_chan_cfg(chan), .o_tx_valid(tx_valid), .o_tx_data(tx_data), .i_tx_ready(tx_ready),
    .o_rst_pulse(rst_pulse), .o_rcl_pulse(rcl_pulse), .o_rcl_slot(rcl_slot), .o_tree_pulse(tree_pulse),
    .o_tree_depth(tree_depth), .o_esr(esr)
  );
  acp_host_model host (
    .i_sys_clk(clk), .i_rx_ready(rx_ready), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_ready(tx_ready)
  );
  always @(negedge clk) begin
    if (rst_pulse === 1'b1) rst_cnt++;
    if (rcl_pulse === 1'b1) rcl_cnt++;
    if (tree_pulse === 1'b1) tree_cnt++;
    if (tree_depth > max_depth) max_depth = tree_depth;
  end
  task automatic tally_and_finish();
    if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic send(input string s);
    bit tmo;
    int n;
    rst_cnt = 0;
    rcl_cnt = 0;
    tree_cnt = 0;
    host.send_line(s, tmo);
    n = 0;
    repeat (3) @(negedge clk);
    while ((!rx_ready || tx_valid) && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (tmo || n == 200) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask
  task automatic t_idn();
    int commas;
    commas = 0;
    host.slow = 1'b1;
    host.resp_q.delete();
    send("*IDN?");
    host.slow = 1'b0;
    `CHK(host.resp_q.size(), ACP_ID_LEN + 1)
    for (int k = 0; k < ACP_ID_LEN; k++) begin
      `CHK(host.resp_q[k], ACP_ID_TEXT[8*(ACP_ID_LEN-1-k) +: 8])
      if (host.resp_q[k] === ACP_CH_COMMA) commas++;
    end
    `CHK(commas, 3)
    `CHK(host.resp_q[ACP_ID_LEN], ACP_CH_NL)
  endtask
  task automatic t_rst();
    send("*rst");
    `CHK(rst_cnt, 1)
    `CHK(esr[ACP_ESR_CME], 1'b0)
  endtask
  task automatic t_multi();
    send("*RST;*RCL 7");
    `CHK(rst_cnt, 1)
    `CHK(rcl_cnt, 1)
    `CHK(rcl_slot, 16'h0007)
  endtask
  task automatic t_rcl_ok();
    for (int i = 0; i < 3; i++) begin
      chan = cfgs[i];
      send($sformatf("*RCL %0d", maxs[i]));
      `CHK(rcl_cnt, 1)
      `CHK(rcl_slot, maxs[i])
    end
  endtask
  task automatic t_err();
    send("*RS");
    `CHK(rst_cnt, 0)
    `CHK(esr[ACP_ESR_CME], 1'b1)
    send("*RST?");
    `CHK(rst_cnt, 0)
    send("RST");
    `CHK(rst_cnt, 0)
  endtask
  task automatic t_fmt();
    host.resp_q.delete();
    send("*IDN?X;*RST");
    `CHK(host.resp_q.size(), 0)
    `CHK(rst_cnt, 1)
    send("*RCL 7,2");
    `CHK(rcl_cnt, 0)
    send("*RCL 1.5");
    `CHK(rcl_cnt, 0)
    send("*RCL 2e1");
    `CHK(rcl_cnt, 0)
  endtask
  task automatic t_rcl_bad();
    for (int i = 0; i < 3; i++) begin
      chan = cfgs[i];
      send($sformatf("*RCL %0d", maxs[i] + 16'h0001));
      `CHK(rcl_cnt, 0)
      `CHK(rcl_slot, ACP_SLOT_MAX4)
    end
    send("*RCL 0");
    `CHK(rcl_cnt, 0)
  endtask
  task automatic t_tree();
    max_depth = 4'h0;
    send("A:B:C");
    `CHK(max_depth, 4'h2)
    `CHK(tree_cnt, 2)
    `CHK(tree_depth, 4'h0)
  endtask
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    chan = ACP_CH1;
    error_cnt = 0;
    tests_run = 0;
    max_depth = 4'h0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    t_idn();
    t_rst();
    t_multi();
    t_rcl_ok();
    t_err();
    t_rcl_bad();
    t_fmt();
    t_tree();
    tally_and_finish();
  end
endmodule
`default_nettype wire
